// ==== design/rcs_top.sv ====
// Two-wire register control slave: link engine on the serial clock.
// Assumes an external pull-up resolves the data line from the enable.
`timescale 1ns/10ps

module rcs_top (
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic I2C_SCL_IN,
   input wire logic I2C_SDA_IN,
   output logic I2C_SDA_OUT,
   output logic I2C_SDA_OE_B_OUT,
   input wire logic AUX_FRAME_CLOCK_STRAP_PIN_IN,
   input wire logic [7:0] REG_RDATA_IN,
   output logic REG_WR_STB_OUT,
   output logic [7:0] REG_WADDR_OUT,
   output logic [7:0] REG_WDATA_OUT,
   output logic [7:0] REG_RADDR_OUT,
   output logic ADDR_LSB_STRAP_OUT
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic addr_match(input logic [7:0] b, input logic strap);
      addr_match = (b[7:2] == rcs_pkg::DEV_ADDR_HI) && (b[1] == strap);
   endfunction

   function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] cnt);
      logic [3:0] idx;
      idx = rcs_pkg::BIT_LAST - cnt;
      tx_bit = b[idx[2:0]];
   endfunction

   // ----------------------------------------------------------------
   // Carrier and system side
   // ----------------------------------------------------------------
   rcs_xfer_if xfer ();

   rcs_sys_bridge rcs_sys_bridge_i (
      .clk_in(CLOCK_IN),
      .rst_b_in(RST_B_IN),
      .strap_pin_in(AUX_FRAME_CLOCK_STRAP_PIN_IN),
      .xfer(xfer.core),
      .reg_rdata_in(REG_RDATA_IN),
      .reg_wr_stb_out(REG_WR_STB_OUT),
      .reg_waddr_out(REG_WADDR_OUT),
      .reg_wdata_out(REG_WDATA_OUT),
      .reg_raddr_out(REG_RADDR_OUT),
      .strap_out(ADDR_LSB_STRAP_OUT)
   );

   wire link_rst_b;
   assign link_rst_b = xfer.link_rst_b;

   // ----------------------------------------------------------------
   // Start and stop detection
   // ----------------------------------------------------------------
   // Clocked by the data line itself: the serial clock may not run around
   // these conditions, so they are caught as toggles and read on the next rise.
   logic start_tgl_reg, stop_tgl_reg;

   always_ff @(negedge I2C_SDA_IN or negedge link_rst_b)
   begin
      if (!link_rst_b)
         start_tgl_reg <= 1'b0;
      else if (I2C_SCL_IN)
         start_tgl_reg <= ~start_tgl_reg; // RULE5
   end

   always_ff @(posedge I2C_SDA_IN or negedge link_rst_b)
   begin
      if (!link_rst_b)
         stop_tgl_reg <= 1'b0;
      else if (I2C_SCL_IN)
         stop_tgl_reg <= ~stop_tgl_reg; // RULE6
   end

   // ----------------------------------------------------------------
   // System-side words into the serial clock domain
   // ----------------------------------------------------------------
   // Both words stand still for many serial clock periods before use, so two
   // stages per bit are enough; a handshake would cost a byte of latency.
   logic strap_lk_s1_reg, strap_lk_s2_reg;
   logic [7:0] rd_lk_s1_reg, rd_lk_s2_reg;

   always_ff @(posedge I2C_SCL_IN or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         strap_lk_s1_reg <= 1'b0;
         strap_lk_s2_reg <= 1'b0;
      end
      else
      begin
         strap_lk_s1_reg <= xfer.strap; // RULE18
         strap_lk_s2_reg <= strap_lk_s1_reg;
      end
   end

   always_ff @(negedge I2C_SCL_IN or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         rd_lk_s1_reg <= rcs_pkg::BYTE_ZERO;
         rd_lk_s2_reg <= rcs_pkg::BYTE_ZERO;
      end
      else
      begin
         rd_lk_s1_reg <= xfer.rd_data; // RULE18
         rd_lk_s2_reg <= rd_lk_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Receive side, rising serial clock
   // ----------------------------------------------------------------
   rcs_pkg::rcs_phase_e phase_reg, phase_next;
   logic [3:0] bitcnt_reg, bitcnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic [7:0] waddr_reg, waddr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic rw_reg, rw_next;
   logic inc_reg, inc_next;
   logic ack_pend_reg, ack_pend_next;
   logic ev_tgl_reg, ev_tgl_next;
   logic ev_wr_reg, ev_wr_next;
   logic start_ack_reg, stop_ack_reg;
   wire new_start, stop_seen;
   wire [7:0] byte_in;

   // Start hold time keeps the toggle settled before the first rising edge
   assign new_start = start_tgl_reg ^ start_ack_reg;
   assign stop_seen = stop_tgl_reg ^ stop_ack_reg;
   assign byte_in = {shift_reg[6:0], I2C_SDA_IN}; // RULE2

   // Named decode of the bit position and of the byte just completed
   wire at_first_bit, at_last_bit, at_ack_bit, in_frame;
   wire prefetch_step, addr_hit, master_nack, inc_loaded;
   wire [7:0] ptr_step, ptr_loaded;

   assign at_first_bit = (bitcnt_reg == rcs_pkg::BIT_FIRST);
   assign at_last_bit = (bitcnt_reg == rcs_pkg::BIT_LAST);
   assign at_ack_bit = (bitcnt_reg == rcs_pkg::BIT_ACK);
   assign in_frame = (phase_reg != rcs_pkg::PH_IDLE);
   assign prefetch_step = (phase_reg == rcs_pkg::PH_RDATA) && at_first_bit && inc_reg;
   assign addr_hit = addr_match(byte_in, strap_lk_s2_reg); // RULE9
   // High in the acknowledge slot of a read: the master wants no more bytes
   assign master_nack = I2C_SDA_IN;
   assign ptr_step = ptr_reg + 8'h01;
   assign ptr_loaded = {1'b0, byte_in[6:0]};
   assign inc_loaded = byte_in[rcs_pkg::PTR_INC_BIT];

   always_comb
   begin
      phase_next = phase_reg;
      bitcnt_next = bitcnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      rw_next = rw_reg;
      inc_next = inc_reg;
      ack_pend_next = ack_pend_reg;
      ev_tgl_next = ev_tgl_reg;
      ev_wr_next = ev_wr_reg;
      if (new_start)
      begin
         // First rise after a start carries the address MSB
         phase_next = rcs_pkg::PH_ADDR; // RULE5 RULE8
         bitcnt_next = rcs_pkg::BIT_AFTER_START;
         shift_next = {7'h00, I2C_SDA_IN};
         ack_pend_next = 1'b0;
      end
      else if (stop_seen)
      begin
         phase_next = rcs_pkg::PH_IDLE; // RULE6
         ack_pend_next = 1'b0;
      end
      else if (in_frame)
      begin
         if (!at_ack_bit)
         begin
            shift_next = byte_in;
            bitcnt_next = bitcnt_reg + 4'h1;
            // Stepping at the first bit gives the bridge a whole byte to fetch
            if (prefetch_step)
            begin
               ptr_next = ptr_step; // RULE12
               ev_tgl_next = ~ev_tgl_reg;
               ev_wr_next = 1'b0;
            end
            if (at_last_bit)
            begin
               case (phase_reg)
                  rcs_pkg::PH_ADDR:
                  begin
                     if (addr_hit) // RULE9
                     begin
                        ack_pend_next = 1'b1;
                        rw_next = byte_in[0]; // RULE8
                     end
                     else
                        phase_next = rcs_pkg::PH_IDLE; // RULE20
                  end
                  rcs_pkg::PH_PTR:
                  begin
                     ptr_next = ptr_loaded; // RULE10 RULE15 RULE16
                     inc_next = inc_loaded;
                     ack_pend_next = 1'b1;
                     ev_tgl_next = ~ev_tgl_reg;
                     ev_wr_next = 1'b0;
                  end
                  rcs_pkg::PH_WDATA:
                  begin
                     ack_pend_next = 1'b1;
                     waddr_next = ptr_reg;
                     wdata_next = byte_in;
                     ev_tgl_next = ~ev_tgl_reg; // RULE21
                     ev_wr_next = 1'b1;
                     if (inc_reg)
                        ptr_next = ptr_step; // RULE12
                  end
                  default:
                     ack_pend_next = 1'b0;
               endcase
            end
         end
         else
         begin
            bitcnt_next = rcs_pkg::BIT_FIRST;
            ack_pend_next = 1'b0;
            case (phase_reg)
               rcs_pkg::PH_ADDR:
                  phase_next = rw_reg ? rcs_pkg::PH_RDATA : rcs_pkg::PH_PTR; // RULE11
               rcs_pkg::PH_PTR:
                  phase_next = rcs_pkg::PH_WDATA;
               rcs_pkg::PH_RDATA:
                  if (master_nack)
                     phase_next = rcs_pkg::PH_IDLE; // RULE14 RULE17
               default:
                  phase_next = phase_reg;
            endcase
         end
      end
   end

   always_ff @(posedge I2C_SCL_IN or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         phase_reg <= rcs_pkg::PH_IDLE;
         bitcnt_reg <= rcs_pkg::BIT_FIRST;
         shift_reg <= rcs_pkg::BYTE_ZERO;
         ptr_reg <= rcs_pkg::PTR_RESET;
         waddr_reg <= rcs_pkg::BYTE_ZERO;
         wdata_reg <= rcs_pkg::BYTE_ZERO;
         rw_reg <= 1'b0;
         inc_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         ev_tgl_reg <= 1'b0;
         ev_wr_reg <= 1'b0;
         start_ack_reg <= 1'b0;
         stop_ack_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= phase_next;
         bitcnt_reg <= bitcnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         rw_reg <= rw_next;
         inc_reg <= inc_next;
         ack_pend_reg <= ack_pend_next;
         ev_tgl_reg <= ev_tgl_next;
         ev_wr_reg <= ev_wr_next;
         start_ack_reg <= start_tgl_reg;
         stop_ack_reg <= stop_tgl_reg;
      end
   end

   assign xfer.ev_tgl = ev_tgl_reg;
   assign xfer.ev_wr = ev_wr_reg;
   assign xfer.ev_waddr = waddr_reg;
   assign xfer.ev_wdata = wdata_reg;
   assign xfer.ptr = ptr_reg;

   // ----------------------------------------------------------------
   // Transmit side, falling serial clock
   // ----------------------------------------------------------------
   // Changing the line only on the falling edge keeps it clear of start and stop
   logic drive_reg, drive_next;
   logic [7:0] tx_reg, tx_next;
   wire is_rx_phase, in_read;

   assign is_rx_phase = (phase_reg == rcs_pkg::PH_ADDR) || (phase_reg == rcs_pkg::PH_PTR)
      || (phase_reg == rcs_pkg::PH_WDATA);
   assign in_read = (phase_reg == rcs_pkg::PH_RDATA);
   wire ack_slot, read_load, read_shift;
   assign ack_slot = is_rx_phase && at_ack_bit && ack_pend_reg;
   assign read_load = in_read && at_first_bit;
   assign read_shift = in_read && (bitcnt_reg < rcs_pkg::BIT_ACK);

   always_comb
   begin
      drive_next = 1'b0;
      tx_next = tx_reg;
      if (ack_slot)
         drive_next = 1'b1; // RULE13
      else if (read_load)
      begin
         // The word was fetched at least a byte earlier and has settled
         tx_next = rd_lk_s2_reg; // RULE11
         drive_next = ~rd_lk_s2_reg[7];
      end
      else if (read_shift)
         drive_next = ~tx_bit(tx_reg, bitcnt_reg); // RULE2
   end

   always_ff @(negedge I2C_SCL_IN or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         drive_reg <= 1'b0;
         tx_reg <= rcs_pkg::BYTE_ZERO;
      end
      else
      begin
         drive_reg <= drive_next; // RULE7
         tx_reg <= tx_next;
      end
   end

   // Open-drain: only ever pulls low; the clock line has no output at all
   assign I2C_SDA_OUT = 1'b0; // RULE1
   assign I2C_SDA_OE_B_OUT = ~drive_reg; // RULE20

endmodule

// ==== design/rcs_pkg.sv ====
// Shared constants and types for the two-wire register control slave.
// Assumes the register file sits outside, on the system clock.
//
// Behaviour
// RULE1 - Target only; clock line is never driven
// RULE2 - Data line sampled and shifted on master clock
// RULE3 - Strap pin latched as address LSB after reset
// RULE4 - Strap high gives 1, low gives 0
// RULE5 - Data falling while clock high restarts framing
// RULE6 - Data rising while clock high ends transaction
// RULE7 - Data changes only while clock is low
// RULE8 - First byte: 7-bit address plus direction bit
// RULE9 - Answer only address 100101 plus strap bit
// RULE10 - Write: byte after address loads pointer
// RULE11 - Read: send selected register after address acknowledge
// RULE12 - Auto-increment flag steps pointer per data byte
// RULE13 - Acknowledge every byte received, address included
// RULE14 - Master acknowledges every byte sent to it
// RULE15 - Master loads pointer by write, then stop
// RULE16 - Pointer-only write changes no register
// RULE17 - Master then restarts, reads, acknowledges, stops
// RULE18 - Control side crosses safely into system domain
// RULE19 - Master keeps lines static when idle
// RULE20 - Address mismatch: release line, ignore until start
// RULE21 - Write at acknowledge; pointer kept without increment (the write strobe is issued while the last data bit is still on the wire)

package rcs_pkg;

   // ----------------------------------------------------------------
   // Address, pointer and bit framing
   // ----------------------------------------------------------------
   localparam logic [5:0] DEV_ADDR_HI = 6'h25;
   localparam int PTR_INC_BIT = 7;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_AFTER_START = 4'h1;

   // ----------------------------------------------------------------
   // Link phases
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_PTR,
      PH_WDATA,
      PH_RDATA
   } rcs_phase_e;

endpackage

// ==== design/rcs_xfer_if.sv ====
// Carrier between the link engine and the system-side bridge.
// Assumes event words are held stable while their toggle crosses.
`timescale 1ns/10ps

interface rcs_xfer_if;
   logic ev_tgl;
   logic ev_wr;
   logic [7:0] ev_waddr;
   logic [7:0] ev_wdata;
   logic [7:0] ptr;
   logic [7:0] rd_data;
   logic strap;
   logic link_rst_b;

   modport link (
      output ev_tgl,
      output ev_wr,
      output ev_waddr,
      output ev_wdata,
      output ptr,
      input rd_data,
      input strap,
      input link_rst_b
   );

   modport core (
      input ev_tgl,
      input ev_wr,
      input ev_waddr,
      input ev_wdata,
      input ptr,
      output rd_data,
      output strap,
      output link_rst_b
   );
endinterface

// ==== design/rcs_sys_bridge.sv ====
// System-clock side: reset, strap capture and register port.
// Assumes the register file answers reads combinationally from the address.
`timescale 1ns/10ps

module rcs_sys_bridge (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic strap_pin_in,
   rcs_xfer_if.core xfer,
   input wire logic [7:0] reg_rdata_in,
   output logic reg_wr_stb_out,
   output logic [7:0] reg_waddr_out,
   output logic [7:0] reg_wdata_out,
   output logic [7:0] reg_raddr_out,
   output logic strap_out
);

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic strap_s1_reg, strap_s2_reg;
   logic ev_s1_reg, ev_s2_reg, ev_s3_reg;
   logic link_rst_b_reg, strap_done_reg, strap_reg;
   logic wr_stb_reg;
   logic [7:0] waddr_reg, wdata_reg, raddr_reg, rdata_reg;
   wire ev_edge;

   always_ff @(posedge clk_in)
   begin
      strap_s1_reg <= strap_pin_in;
      strap_s2_reg <= strap_s1_reg;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         ev_s1_reg <= 1'b0;
         ev_s2_reg <= 1'b0;
         ev_s3_reg <= 1'b0;
      end
      else
      begin
         ev_s1_reg <= xfer.ev_tgl;
         ev_s2_reg <= ev_s1_reg;
         ev_s3_reg <= ev_s2_reg;
      end
   end

   assign ev_edge = ev_s2_reg ^ ev_s3_reg; // RULE18

   // ----------------------------------------------------------------
   // Reset of the link side and strap capture
   // ----------------------------------------------------------------
   // The link clock may be stopped, so its reset is asynchronous, driven from a flop
   always_ff @(posedge clk_in)
   begin
      link_rst_b_reg <= rst_b_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         strap_done_reg <= 1'b0;
         strap_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         strap_done_reg <= 1'b1;
         strap_reg <= strap_s2_reg; // RULE3 RULE4
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   // Event words stay still for a whole byte, so sampling them at the edge is safe
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         wr_stb_reg <= 1'b0;
         waddr_reg <= rcs_pkg::BYTE_ZERO;
         wdata_reg <= rcs_pkg::BYTE_ZERO;
         raddr_reg <= rcs_pkg::PTR_RESET;
         rdata_reg <= rcs_pkg::BYTE_ZERO;
      end
      else
      begin
         wr_stb_reg <= ev_edge & xfer.ev_wr; // RULE21
         if (ev_edge)
         begin
            waddr_reg <= xfer.ev_waddr;
            wdata_reg <= xfer.ev_wdata;
            raddr_reg <= xfer.ptr; // RULE18
         end
         rdata_reg <= reg_rdata_in;
      end
   end

   assign xfer.link_rst_b = link_rst_b_reg;
   assign xfer.strap = strap_reg;
   assign xfer.rd_data = rdata_reg;
   assign reg_wr_stb_out = wr_stb_reg;
   assign reg_waddr_out = waddr_reg;
   assign reg_wdata_out = wdata_reg;
   assign reg_raddr_out = raddr_reg;
   assign strap_out = strap_reg;

endmodule

// ==== test/rcs_properties.sv ====
// Concurrent checks on the ports of the two-wire control slave.
// Assumes one system clock samples every port, link lines included.
`timescale 1ns/10ps

module rcs_properties (
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic I2C_SCL_IN,
   input wire logic I2C_SDA_IN,
   input wire logic I2C_SDA_OUT,
   input wire logic I2C_SDA_OE_B_OUT,
   input wire logic AUX_FRAME_CLOCK_STRAP_PIN_IN,
   input wire logic [7:0] REG_RDATA_IN,
   input wire logic REG_WR_STB_OUT,
   input wire logic [7:0] REG_WADDR_OUT,
   input wire logic [7:0] REG_WDATA_OUT,
   input wire logic [7:0] REG_RADDR_OUT,
   input wire logic ADDR_LSB_STRAP_OUT
);
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   // ------
   // Link
   // ------
   a_sda_const: assert property (I2C_SDA_OUT == 1'b0)
      else $error("data pin value not low");
   a_sda_lowscl: assert property ($changed(I2C_SDA_OE_B_OUT) |-> !I2C_SCL_IN)
      else $error("data enable moved while clock high");

   // ------
   // Register port
   // ------
   a_stb_spacing: assert property (REG_WR_STB_OUT |=> !REG_WR_STB_OUT [*8])
      else $error("write strobes too close");
   a_wr_hold: assert property (REG_WR_STB_OUT |=>
      ($stable(REG_WADDR_OUT) && $stable(REG_WDATA_OUT)) [*4])
      else $error("write address or data moved after strobe");
   a_ptr_follow: assert property (REG_WR_STB_OUT |-> ##[0:2]
      (REG_RADDR_OUT == REG_WADDR_OUT || REG_RADDR_OUT == REG_WADDR_OUT + 8'h01))
      else $error("pointer does not follow write address");
   // Write lands while the last data bit is still on the wire
   a_wr_in_bit8: assert property ($rose(REG_WR_STB_OUT) |-> I2C_SCL_IN)
      else $error("write strobe outside last bit");

   // ------
   // Strap
   // ------
   a_strap_hold: assert property (RST_B_IN && $past(RST_B_IN, 2) |->
      $stable(ADDR_LSB_STRAP_OUT))
      else $error("strap bit changed after reset");
   a_strap_val: assert property ($rose(RST_B_IN) |-> ##2
      (ADDR_LSB_STRAP_OUT == $past(AUX_FRAME_CLOCK_STRAP_PIN_IN, 4)))
      else $error("strap bit differs from pin level");

   c_write: cover property (REG_WR_STB_OUT);
   c_ack: cover property ($fell(I2C_SDA_OE_B_OUT));
   c_strap_one: cover property (ADDR_LSB_STRAP_OUT && !I2C_SDA_IN);
endmodule

// ==== test/rcs_host_model.sv ====
// Behavioural two-wire bus master for the control slave.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/10ps

module rcs_host_model (
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   // Quarter of the 125 ns serial clock period
   localparam realtime Q = 31.25;

   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // ------
   // Bus cycles
   // ------
   task automatic put(input logic v);
      sda_low_out = !v;
      #Q scl_out = 1'b1;
      #(2 * Q) scl_out = 1'b0;
      #Q;
   endtask

   task automatic start();
      sda_low_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q sda_low_out = 1'b1;
      #Q scl_out = 1'b0;
      #Q;
   endtask

   // Lines stay high and still until the next frame
   task automatic stop();
      sda_low_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_low_out = 1'b0;
      #Q;
   endtask

   task automatic send(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--)
         put(v[i]);
      sda_low_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q ack = !sda_in;
      #Q scl_out = 1'b0;
      #Q;
   endtask

   task automatic recv(input logic mack, output logic [7:0] v);
      sda_low_out = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         #Q scl_out = 1'b1;
         #Q v[i] = sda_in;
         #Q scl_out = 1'b0;
         #Q;
      end
      put(!mack);
   endtask
endmodule

// ==== test/tb_rcs_top.sv ====
// Bench for rcs_top: host model on the link, register file on the port.
// Assumes the host model owns the serial clock between frames.
`timescale 1ns/10ps

module tb_rcs_top;
   logic clk;
   logic rst_b;
   logic pin;
   logic strap;
   logic scl;
   logic host_low;
   logic sda;
   logic sda_out;
   logic oe_b;
   logic stb;
   logic lsb;
   logic [7:0] rdata;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic [7:0] raddr;
   logic [7:0] regs [0:255];
   logic a;
   logic [7:0] b;
   int miscompares = 0;
   int checked = 0;
   int n_wr = 0;

   // Open-drain wire with pull-up
   assign sda = !(host_low || oe_b === 1'b0);
   assign rdata = regs[raddr];

   rcs_top rcs_top_i (
      .CLOCK_IN(clk), .RST_B_IN(rst_b), .I2C_SCL_IN(scl), .I2C_SDA_IN(sda),
      .I2C_SDA_OUT(sda_out), .I2C_SDA_OE_B_OUT(oe_b),
      .AUX_FRAME_CLOCK_STRAP_PIN_IN(pin), .REG_RDATA_IN(rdata),
      .REG_WR_STB_OUT(stb), .REG_WADDR_OUT(waddr), .REG_WDATA_OUT(wdata),
      .REG_RADDR_OUT(raddr), .ADDR_LSB_STRAP_OUT(lsb)
   );
   rcs_host_model rcs_host_model_i (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
      if (stb === 1'b1)
      begin
         regs[waddr] <= wdata;
         n_wr <= n_wr + 1;
      end

   // ------
   // Helpers
   // ------
   function automatic logic [7:0] adr(input logic rw);
      return {rcs_pkg::DEV_ADDR_HI, strap, rw};
   endfunction

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic do_reset(input logic s);
      @(negedge clk);
      pin = s;
      strap = s;
      rst_b = 1'b0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] v, input logic e);
      rcs_host_model_i.send(v, a);
      chk("ack", {7'h00, a}, {7'h00, e});
   endtask

   task automatic rd(input logic mack, input logic [7:0] e);
      rcs_host_model_i.recv(mack, b);
      chk("rdata", b, e);
   endtask

   task automatic open_wr(input logic [7:0] p);
      rcs_host_model_i.start();
      wr(adr(1'b0), 1'b1);
      wr(p, 1'b1);
   endtask

   task automatic open_rd();
      rcs_host_model_i.start();
      wr(adr(1'b1), 1'b1);
   endtask

   // Stop, then let the pointer and strobe cross into the system clock
   task automatic close();
      rcs_host_model_i.stop();
      repeat (10) @(negedge clk);
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_strap();
      chk("strap", {7'h00, lsb}, 8'h01);
      pin = 1'b0;
      repeat (10) @(negedge clk);
      chk("strap", {7'h00, lsb}, 8'h01);
      pin = 1'b1;
      $display("t_strap done");
   endtask

   task automatic t_write();
      open_wr(8'h85);
      wr(8'hA1, 1'b1);
      wr(8'hA2, 1'b1);
      close();
      chk("reg5", regs[5], 8'hA1);
      chk("reg6", regs[6], 8'hA2);
      chk("ptr", raddr, 8'h07);
      chk("writes", n_wr[7:0], 8'h02);
      $display("t_write done");
   endtask

   task automatic t_pre_read();
      open_wr(8'h05);
      close();
      chk("writes", n_wr[7:0], 8'h02);
      chk("ptr", raddr, 8'h05);
      open_rd();
      rd(1'b1, 8'hA1);
      rd(1'b0, 8'hA1);
      close();
      chk("ptr", raddr, 8'h05);
      $display("t_pre_read done");
   endtask

   task automatic t_read_inc();
      open_wr(8'h85);
      open_rd();
      rd(1'b1, 8'hA1);
      rd(1'b0, 8'hA2);
      close();
      chk("ptr", raddr, 8'h07);
      $display("t_read_inc done");
   endtask

   task automatic t_mismatch();
      logic [7:0] bad [2];
      bad[0] = {rcs_pkg::DEV_ADDR_HI, !strap, 1'b0};
      bad[1] = {6'h24, strap, 1'b0};
      for (int i = 0; i < 2; i++)
      begin
         rcs_host_model_i.start();
         wr(bad[i], 1'b0);
         wr(8'h33, 1'b0);
         close();
      end
      chk("writes", n_wr[7:0], 8'h02);
      chk("ptr", raddr, 8'h07);
      $display("t_mismatch done");
   endtask

   task automatic t_reset2();
      do_reset(1'b0);
      chk("strap", {7'h00, lsb}, 8'h00);
      chk("ptr", raddr, rcs_pkg::PTR_RESET);
      open_wr(8'h10);
      wr(8'h3C, 1'b1);
      close();
      chk("reg16", regs[16], 8'h3C);
      chk("writes", n_wr[7:0], 8'h03);
      chk("ptr", raddr, 8'h10);
      $display("t_reset2 done");
   endtask

   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      rst_b = 1'b0;
      pin = 1'b1;
      strap = 1'b1;
      for (int i = 0; i < 256; i++)
         regs[i] = i[7:0];
      do_reset(1'b1);
      t_strap();
      t_write();
      t_pre_read();
      t_read_inc();
      t_mismatch();
      t_reset2();
      tally_and_finish();
   end

   // Sequence needs about 26 us; allow a wide margin
   initial
   begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule

bind rcs_top rcs_properties rcs_properties_i (
   .CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .I2C_SCL_IN(I2C_SCL_IN),
   .I2C_SDA_IN(I2C_SDA_IN), .I2C_SDA_OUT(I2C_SDA_OUT), .I2C_SDA_OE_B_OUT(I2C_SDA_OE_B_OUT),
   .AUX_FRAME_CLOCK_STRAP_PIN_IN(AUX_FRAME_CLOCK_STRAP_PIN_IN), .REG_RDATA_IN(REG_RDATA_IN),
   .REG_WR_STB_OUT(REG_WR_STB_OUT), .REG_WADDR_OUT(REG_WADDR_OUT),
   .REG_WDATA_OUT(REG_WDATA_OUT), .REG_RADDR_OUT(REG_RADDR_OUT),
   .ADDR_LSB_STRAP_OUT(ADDR_LSB_STRAP_OUT)
);
